// ===== sram_pkg.sv
`default_nettype none
// ==========================================================
// shared constants and types for the burst sram front end
package sram_pkg;
    // ======================================================
    // array geometry defaults
    localparam int ADDR_W_DEF  = 20;   // word address width
    localparam int LANES_DEF   = 4;    // byte lanes per word
    localparam int LANE_W_DEF  = 9;    // bits per lane, parity bit included
    localparam int CHK_W_DEF   = 6;    // hidden check bits per word
    localparam int BURST_LO_W  = 2;    // burst counter width

    // ======================================================
    // burst order encodings on the order strap
    localparam logic ORDER_LINEAR      = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    // ======================================================
    // reset values
    localparam logic [BURST_LO_W-1:0] BURST_LO_RST = 2'h0;
    localparam logic                  OE_N_RST     = 1'b1;  // tristated

    // ======================================================
    // timing: times in ns, counts derived at the clock rate
    localparam int CLOCK_PERIOD_NS          = 40;
    localparam int SLEEP_ENTRY_TIME_NS      = 2 * CLOCK_PERIOD_NS;  // longest
    localparam int SLEEP_EXIT_QUIET_TIME_NS = 2 * CLOCK_PERIOD_NS;  // least
    // longest time rounds down, never below one cycle
    localparam int SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        SLEEP_ENTRY_TIME_NS / CLOCK_PERIOD_NS;
    // least time rounds up
    localparam int SLEEP_EXIT_QUIET_CYC =
        (SLEEP_EXIT_QUIET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ======================================================
    // decoded bus cycle kinds
    typedef enum logic [2:0] {
        CYC_IDLE,
        CYC_DESEL,
        CYC_BEGIN_RD,
        CYC_BEGIN_WR,
        CYC_CONT,
        CYC_SUSP
    } cyc_t;
endpackage : sram_pkg
`default_nettype wire

// ===== burst_counter.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// two-bit wraparound burst counter, linear or interleaved
module burst_counter
    import sram_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // control
    input  wire logic                  load,      // strobe-started access
    input  wire logic                  step,      // continue-burst cycle
    input  wire logic                  order_in,  // sampled at load
    input  wire logic [BURST_LO_W-1:0] start_in,  // low address bits
    // burst address low bits
    output logic      [BURST_LO_W-1:0] cur_lo,    // current address
    output logic      [BURST_LO_W-1:0] step_lo    // address after a step
);
    logic [BURST_LO_W-1:0] start;   // latched first address
    logic [BURST_LO_W-1:0] cnt;     // beats advanced so far
    logic                  order;   // latched order
    logic [BURST_LO_W-1:0] cnt_inc; // count plus one, wraps

    // ======================================================
    // start and order kept until the next load, count wraps forever
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            start <= BURST_LO_RST;
            cnt   <= BURST_LO_RST;
            order <= ORDER_INTERLEAVED;
        end else if (load) begin
            start <= start_in;
            cnt   <= BURST_LO_RST;
            order <= order_in;
        end else if (step) begin
            cnt   <= cnt_inc;
        end
    end

    assign cnt_inc = BURST_LO_W'(cnt + 2'h1);
    // interleaved xors the count in, linear adds it
    assign cur_lo  = (order == ORDER_INTERLEAVED) ? (start ^ cnt)
                   : BURST_LO_W'(start + cnt);
    assign step_lo = (order == ORDER_INTERLEAVED) ? (start ^ cnt_inc)
                   : BURST_LO_W'(start + cnt_inc);

    // ======================================================
    // checks
    property p_interleave_second;
        @(posedge core_clk) disable iff (sys_rst)
        (load && order_in == ORDER_INTERLEAVED) ##1 (step && !load)
            |-> step_lo == ($past(start_in) ^ 2'h1);
    endproperty
    a_interleave_second: assert property (p_interleave_second)
        else $error("interleaved second address wrong");

    property p_linear_third;
        @(posedge core_clk) disable iff (sys_rst)
        (load && order_in == ORDER_LINEAR) ##1 (step && !load) [*2]
            |=> cur_lo == BURST_LO_W'($past(start_in, 3) + 2'h2);
    endproperty
    a_linear_third: assert property (p_linear_third)
        else $error("linear third address wrong");
endmodule : burst_counter
`default_nettype wire

// ===== sleep_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// sleep request synchroniser, sets the entry and exit latency
module sleep_sync
    import sram_pkg::*;
#(
    parameter int STAGES = SLEEP_ENTRY_CYC  // flops in the chain
)(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // sleep request in, sleep state out
    input  wire logic sleep_request,
    output logic      sleep_state
);
    logic [STAGES-1:0] chain;  // bit 0 is read only by bit 1

    // ======================================================
    // plain shift chain; the first stage feeds nothing but the next
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], sleep_request};
        end
    end

    assign sleep_state = chain[STAGES-1];

    // ======================================================
    // checks
    property p_entry_two;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(sleep_request) ##1 sleep_request |-> !sleep_state ##1 sleep_state;
    endproperty
    a_entry_two: assert property (p_entry_two)
        else $error("sleep entry not two cycles");

    property p_exit_two;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(sleep_request) ##1 !sleep_request |-> sleep_state ##1 !sleep_state;
    endproperty
    a_exit_two: assert property (p_exit_two)
        else $error("sleep exit not two cycles");
endmodule : sleep_sync
`default_nettype wire

// ===== sync_burst_sram_interface.sv
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_interface
    import sram_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,  // word address width
    parameter int LANES  = LANES_DEF,   // byte lanes
    parameter int LANE_W = LANE_W_DEF,  // bits per lane
    parameter int CHK_W  = CHK_W_DEF,   // check bits per word
    parameter bit ECC_EN = 1'b1         // error-correcting variant
)(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // address and selects
    input  wire logic [ADDR_W-1:0]       addr,
    input  wire logic                    chip_sel_first_n,
    input  wire logic                    chip_sel_second,
    input  wire logic                    chip_sel_third_n,
    // burst control
    input  wire logic                    proc_addr_strobe_n,
    input  wire logic                    ctrl_addr_strobe_n,
    input  wire logic                    burst_step_n,
    input  wire logic                    burst_order,   // tie high if unused
    // write control
    input  wire logic                    all_bytes_write_n,
    input  wire logic                    byte_write_gate_n,
    input  wire logic [LANES-1:0]        lane_write_sel_n,
    // output enable and sleep
    input  wire logic                    out_enable_n,
    input  wire logic                    sleep_request,
    // data pins, split into in, out and enable
    input  wire logic [LANES*LANE_W-1:0] data_in,
    output logic      [LANES*LANE_W-1:0] data_out,
    output logic                         data_oe_n,     // low while driving
    // status
    output logic                         sleep_state,
    output logic                         ecc_fixed      // read was corrected
);
    localparam int DATA_W = LANES * LANE_W;
    localparam int CW     = DATA_W + CHK_W;  // codeword positions

    // ======================================================
    // storage: data and hidden check bits
    logic [DATA_W-1:0] mem_data [2**ADDR_W];  // user data
    logic [CHK_W-1:0]  mem_chk  [2**ADDR_W];  // never on the pins

    // ======================================================
    // decode signals
    cyc_t                  cyc;          // this cycle's kind
    logic                  sel_all;      // all three selects active
    logic                  asleep;       // inputs ignored
    logic                  write_n;      // internal write qualifier
    logic                  is_write;     // this cycle writes
    logic                  is_read;      // this cycle reads
    logic                  burst_active; // a burst may continue
    logic [ADDR_W-1:BURST_LO_W] base_hi; // upper address of the burst
    logic [BURST_LO_W-1:0] cur_lo;       // counter, current beat
    logic [BURST_LO_W-1:0] step_lo;      // counter, next beat
    logic [ADDR_W-1:0]     acc_addr;     // address used this cycle
    logic [DATA_W-1:0]     rd_fixed;     // corrected stored word
    logic [CHK_W-1:0]      syndrome;     // nonzero on a bad word
    logic [DATA_W-1:0]     wr_word;      // merged word to store
    logic [LANES-1:0]      lane_we;      // lanes written this cycle

    // ======================================================
    // hamming check bits: each data bit sits at a non-power-of-two
    // position, check bits collect the xor of those positions
    function automatic logic [CHK_W-1:0] calc_chk(input logic [DATA_W-1:0] d);
        int k;
        logic [CHK_W-1:0] c;
        c = '0;
        k = 0;
        for (int p = 1; p <= CW; p++) begin
            if ((p & (p - 1)) != 0 && k < DATA_W) begin
                c = c ^ ({CHK_W{d[k]}} & CHK_W'(p));
                k = k + 1;
            end
        end
        return c;
    endfunction : calc_chk

    // flip the data bit that the syndrome points at; a syndrome that
    // names a check bit or nothing leaves the data alone, and two bad
    // bits may be miscorrected
    function automatic logic [DATA_W-1:0] fix_word(input logic [DATA_W-1:0] d,
                                                   input logic [CHK_W-1:0]  s);
        int k;
        logic [DATA_W-1:0] r;
        r = d;
        k = 0;
        for (int p = 1; p <= CW; p++) begin
            if ((p & (p - 1)) != 0 && k < DATA_W) begin
                if (CHK_W'(p) == s) begin
                    r[k] = ~d[k];
                end
                k = k + 1;
            end
        end
        return r;
    endfunction : fix_word

    // ======================================================
    // sleep synchroniser
    sleep_sync #(
        .STAGES (SLEEP_ENTRY_CYC)
    ) u_sleep (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .sleep_request (sleep_request),
        .sleep_state   (sleep_state)
    );

    // raw request gates at once so nothing starts once it is seen
    assign asleep  = sleep_request || sleep_state;
    assign sel_all = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;

    // global write wins; else gate with any lane selected
    assign write_n = all_bytes_write_n &&
                     !(!byte_write_gate_n && (lane_write_sel_n != '1));

    // ======================================================
    // cycle decode; processor strobe is dropped when the first
    // select is high, and it overrides the controller strobe
    always_comb begin
        cyc = CYC_IDLE;
        if (asleep) begin
            cyc = CYC_IDLE;
        end else if (!proc_addr_strobe_n && !chip_sel_first_n) begin
            // write inputs ignored in this cycle
            cyc = sel_all ? CYC_BEGIN_RD : CYC_DESEL;
        end else if (!ctrl_addr_strobe_n) begin
            if (!sel_all) begin
                cyc = CYC_DESEL;
            end else begin
                cyc = write_n ? CYC_BEGIN_RD : CYC_BEGIN_WR;
            end
        end else if (burst_active) begin
            cyc = burst_step_n ? CYC_SUSP : CYC_CONT;
        end
    end

    assign is_write = (cyc == CYC_BEGIN_WR) ||
                      ((cyc == CYC_CONT || cyc == CYC_SUSP) && !write_n);
    assign is_read  = (cyc == CYC_BEGIN_RD) ||
                      ((cyc == CYC_CONT || cyc == CYC_SUSP) && write_n);

    // ======================================================
    // burst counter
    burst_counter u_burst (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .load     (cyc == CYC_BEGIN_RD || cyc == CYC_BEGIN_WR),
        .step     (cyc == CYC_CONT),
        .order_in (burst_order),
        .start_in (addr[BURST_LO_W-1:0]),
        .cur_lo   (cur_lo),
        .step_lo  (step_lo)
    );

    // address used: external, next or current beat
    always_comb begin
        acc_addr = addr;
        if (cyc == CYC_CONT) begin
            acc_addr = {base_hi, step_lo};
        end else if (cyc == CYC_SUSP) begin
            acc_addr = {base_hi, cur_lo};
        end
    end

    // ======================================================
    // burst tracking; deselect and sleep end the burst, so an
    // access caught by sleep is simply dropped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            burst_active <= 1'b0;
        end else if (asleep || cyc == CYC_DESEL) begin
            burst_active <= 1'b0;
        end else if (cyc == CYC_BEGIN_RD || cyc == CYC_BEGIN_WR) begin
            burst_active <= 1'b1;
        end
    end

    // upper address bits held for the whole burst
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            base_hi <= '0;
        end else if (cyc == CYC_BEGIN_RD || cyc == CYC_BEGIN_WR) begin
            base_hi <= addr[ADDR_W-1:BURST_LO_W];
        end
    end

    // ======================================================
    // read path with correction
    assign syndrome = ECC_EN ? (mem_chk[acc_addr] ^ calc_chk(mem_data[acc_addr]))
                             : '0;
    assign rd_fixed = ECC_EN ? fix_word(mem_data[acc_addr], syndrome)
                             : mem_data[acc_addr];

    // lane merge: partial writes keep the corrected old lanes
    assign lane_we = !all_bytes_write_n ? '1 : ~lane_write_sel_n;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign wr_word[g*LANE_W +: LANE_W] = lane_we[g] ?
                data_in[g*LANE_W +: LANE_W] : rd_fixed[g*LANE_W +: LANE_W];
        end
    endgenerate

    // ======================================================
    // array update; no reset, and sleep never touches it
    always_ff @(posedge core_clk) begin
        if (is_write) begin
            mem_data[acc_addr] <= wr_word;
            mem_chk[acc_addr]  <= calc_chk(wr_word);
        end
    end

    // ======================================================
    // data pins: drive only on a selected read with enable low;
    // enable is sampled here so the pin timing is one edge late
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            data_oe_n <= OE_N_RST;
        end else begin
            data_oe_n <= !(is_read && !out_enable_n);
        end
    end

    // flow-through read word, held when not reading
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            data_out <= '0;
        end else if (is_read) begin
            data_out <= rd_fixed;
        end
    end

    // correction flag, one cycle per corrected read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ecc_fixed <= 1'b0;
        end else begin
            ecc_fixed <= is_read && (syndrome != '0);
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_desel_tristate;
        chip_sel_first_n && !ctrl_addr_strobe_n |=> data_oe_n;
    endproperty
    a_desel_tristate: assert property (p_desel_tristate)
        else $error("deselect cycle drove data pins");

    property p_proc_read;
        !proc_addr_strobe_n && sel_all && !out_enable_n && !asleep
            |=> !data_oe_n;
    endproperty
    a_proc_read: assert property (p_proc_read)
        else $error("processor strobe did not start a read");

    property p_ctrl_write_quiet;
        proc_addr_strobe_n && !ctrl_addr_strobe_n && sel_all && !asleep &&
        !byte_write_gate_n && lane_write_sel_n != '1 |=> data_oe_n [*1];
    endproperty
    a_ctrl_write_quiet: assert property (p_ctrl_write_quiet)
        else $error("data pins driven in a write");

    property p_write_readback;
        (proc_addr_strobe_n && !ctrl_addr_strobe_n && sel_all && !asleep &&
         !all_bytes_write_n)
        ##1 (proc_addr_strobe_n && !ctrl_addr_strobe_n && sel_all && !asleep &&
             !out_enable_n && write_n && addr == $past(addr))
        |=> data_out == $past(data_in, 2) && !data_oe_n;
    endproperty
    a_write_readback: assert property (p_write_readback)
        else $error("written word not read back");

    property p_sleep_tristate;
        sleep_request |=> data_oe_n;
    endproperty
    a_sleep_tristate: assert property (p_sleep_tristate)
        else $error("data pins driven in sleep");

    property p_sleep_ends_burst;
        sleep_state |=> !burst_active;
    endproperty
    a_sleep_ends_burst: assert property (p_sleep_ends_burst)
        else $error("burst survived sleep");
endmodule : sync_burst_sram_interface
`default_nettype wire

// ===== bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// cache controller model on the far side of the sram bus
module bus_master_model (
    // clock
    input  wire logic        core_clk,
    // device side of the shared data pins
    input  wire logic [35:0] data_out,
    input  wire logic        data_oe_n,
    output logic      [35:0] data_in,
    // {sleep, proc, ctrl, selects, step, order, global, gate, lanes}
    output logic      [13:0] ctl,
    output logic      [5:0]  addr,
    output logic             out_enable_n
);
    logic [35:0] wdata;          // write data held on the pins
    logic        drv;            // master drives the pins
    logic        was_wr = 1'b0;  // previous cycle was a write
    logic [35:0] last   = '0;    // last pin level, for a floating bus

    // ======================================================
    // pin level: device first, then master, else a drifting bus
    assign data_in = !data_oe_n ? data_out : drv ? wdata : ~last;

    // released pins never keep the old value
    always @(posedge core_clk) begin
        last <= data_in;
    end

    // ======================================================
    // one bus cycle, held until the next call
    task automatic drive(input logic [13:0] c, input logic [5:0] a,
                         input logic [35:0] d, input logic oe);
        logic wr;
        // no write in a processor-strobe start cycle
        wr = c[12] && (!c[5] || (!c[4] && !(&c[3:0])));
        ctl = c;
        addr = a;
        wdata = d;
        drv = wr;
        // output enable forced high in a write's first cycle
        out_enable_n = oe | (wr & !was_wr);
        was_wr = wr;
    endtask : drive
endmodule : bus_master_model
`default_nettype wire

// ===== sync_burst_sram_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// self-checking bench for the burst sram front end
module sync_burst_sram_interface_tb;
    localparam logic [1:0]  PS = 2'b01, CS = 2'b10, NS = 2'b11;  // strobes
    localparam logic [2:0]  ON = 3'b010, OFF = 3'b101;          // selects
    localparam logic [5:0]  RD = 6'h3f, GW = 6'h1f;             // write inputs
    localparam logic [13:0] SLP = 14'h2000;                     // sleep bit
    logic        core_clk;          // bench clock
    logic        sys_rst;           // sync reset
    logic [13:0] ctl;               // packed bus controls
    logic [5:0]  addr;              // word address
    logic        oe_n;              // output enable
    logic [35:0] data_in;           // resolved pins
    logic [35:0] data_out;          // read data
    logic        data_oe_n;         // pin enable
    logic        sleep_state;       // asleep
    logic        ecc_fixed;         // correction pulse
    int          error_cnt = 0;     // mismatches
    int          checks_done = 0;   // comparisons
    typedef struct packed {logic order; logic [1:0] start; logic [7:0] seq;} row_t;
    // burst order, start bits and the four expected beats
    row_t rows [5] = '{'{1'b0, 2'h2, 8'hb1}, '{1'b0, 2'h3, 8'hc6},
        '{1'b1, 2'h1, 8'h4e}, '{1'b1, 2'h3, 8'he4}, '{1'b1, 2'h0, 8'h1b}};

    sync_burst_sram_interface #(.ADDR_W(6)) u_sync_burst_sram_interface (
        .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr),
        .chip_sel_first_n(ctl[10]), .chip_sel_second(ctl[9]), .chip_sel_third_n(ctl[8]),
        .proc_addr_strobe_n(ctl[12]), .ctrl_addr_strobe_n(ctl[11]),
        .burst_step_n(ctl[7]), .burst_order(ctl[6]), .all_bytes_write_n(ctl[5]),
        .byte_write_gate_n(ctl[4]), .lane_write_sel_n(ctl[3:0]), .out_enable_n(oe_n),
        .sleep_request(ctl[13]), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .sleep_state(sleep_state), .ecc_fixed(ecc_fixed));
    bus_master_model u_bus_master_model (
        .core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .ctl(ctl), .addr(addr), .out_enable_n(oe_n));

    // ======================================================
    // helpers
    function automatic logic [13:0] bus(input logic [1:0] s, input logic [2:0] c,
                                        input logic st, input logic o, input logic [5:0] w);
        return {1'b0, s, c, st, o, w};
    endfunction : bus
    function automatic logic [35:0] pat(input logic [5:0] a);
        return 36'h9a5c30000 | {30'h0, a};
    endfunction : pat
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string n, input logic [35:0] e, input logic [35:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    // one bus cycle, driven just after the edge; its result shows after the next
    task automatic cyc(input logic [13:0] c, input logic [5:0] a, input logic [35:0] d,
                       input logic o);
        @(posedge core_clk);
        #1;
        u_bus_master_model.drive(c, a, d, o);
    endtask : cyc
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // ======================================================
    // clock and watchdog, well past the expected run length
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end

    // ======================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        u_bus_master_model.drive(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        repeat (20) @(posedge core_clk);
        #1;
        chk_bit("reset pin enable", 1'b1, data_oe_n);
        chk_bit("reset sleep", 1'b0, sleep_state);
        chk_bit("reset correction", 1'b0, ecc_fixed);
        sys_rst = 1'b0;
        // fill words 4..7 by controller-strobe writes
        for (int a = 4; a < 8; a++) begin
            cyc(bus(CS, ON, 1'b1, 1'b1, GW), 6'(a), pat(6'(a)), 1'b1);
        end
        // bursts; order flips and address drops to zero on later beats, both must be ignored
        foreach (rows[i]) begin
            cyc(bus(PS, ON, 1'b1, rows[i].order, RD), {4'h1, rows[i].start}, 36'h0, 1'b0);
            for (int b = 0; b < 5; b++) begin
                cyc(bus(NS, ON, 1'b0, ~rows[i].order, RD), 6'h0, 36'h0, 1'b0);
                chk_word("burst beat", pat({4'h1, rows[i].seq[7-2*(b%4) -: 2]}), data_out);
                chk_bit("burst pin enable", 1'b0, data_oe_n);
                chk_bit("no correction", 1'b0, ecc_fixed);
            end
        end
        // both strobes low with write inputs active: a read, nothing written
        cyc(bus(2'b00, ON, 1'b1, 1'b1, 6'h00), 6'h5, ~pat(6'h5), 1'b0);
        cyc(bus(NS, ON, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        chk_word("processor start read", pat(6'h5), data_out);
        cyc(bus(NS, ON, 1'b1, 1'b1, GW), 6'h0, 36'h123456789, 1'b0);
        chk_bit("read with enable high", 1'b1, data_oe_n);
        cyc(bus(NS, ON, 1'b0, 1'b1, GW), 6'h0, 36'h0badc0de5, 1'b0);
        cyc(bus(CS, ON, 1'b1, 1'b1, RD), 6'h5, 36'h0, 1'b0);
        chk_bit("write masks enable", 1'b1, data_oe_n);
        cyc(bus(CS, ON, 1'b1, 1'b1, RD), 6'h4, 36'h0, 1'b0);
        chk_word("suspend write", 36'h123456789, data_out);
        cyc(bus(CS, 3'b110, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b0);
        chk_word("continue write", 36'h0badc0de5, data_out);
        // lanes 0 and 2 through the gate, then gate high with lanes low reads
        cyc(bus(CS, ON, 1'b1, 1'b1, 6'h2a), 6'h6, 36'h0, 1'b1);
        cyc(bus(CS, ON, 1'b1, 1'b1, 6'h30), 6'h6, 36'hfffffffff, 1'b0);
        cyc(bus(CS, 3'b110, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b0);
        chk_word("lane write", pat(6'h6) & ~36'h007fc01ff, data_out);
        chk_bit("gate high reads", 1'b0, data_oe_n);
        // deselect forms and a step with no burst open
        cyc(bus(CS, 3'b000, 1'b1, 1'b1, RD), 6'h6, 36'h0, 1'b0);
        chk_bit("first select high", 1'b1, data_oe_n);
        cyc(bus(NS, ON, 1'b0, 1'b1, RD), 6'h6, 36'h0, 1'b0);
        chk_bit("second select low", 1'b1, data_oe_n);
        cyc(bus(PS, ON, 1'b1, 1'b1, RD), 6'h6, 36'h0, 1'b1);
        chk_bit("step without burst", 1'b1, data_oe_n);
        cyc(bus(CS, 3'b110, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b0);
        chk_bit("read enable high", 1'b1, data_oe_n);
        // sleep entered while deselected, a read attempted meanwhile
        cyc(bus(CS, 3'b110, 1'b1, 1'b1, RD) | SLP, 6'h0, 36'h0, 1'b0);
        cyc(bus(PS, ON, 1'b1, 1'b1, RD) | SLP, 6'h6, 36'h0, 1'b0);
        chk_bit("sleep after one edge", 1'b0, sleep_state);
        cyc(bus(PS, ON, 1'b1, 1'b1, RD) | SLP, 6'h6, 36'h0, 1'b0);
        chk_bit("sleep after two edges", 1'b1, sleep_state);
        chk_bit("asleep pins", 1'b1, data_oe_n);
        cyc(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        cyc(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        chk_bit("wake after one edge", 1'b1, sleep_state);
        cyc(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        chk_bit("wake after two edges", 1'b0, sleep_state);
        cyc(bus(PS, ON, 1'b1, 1'b1, RD), 6'h7, 36'h0, 1'b0);
        cyc(bus(CS, 3'b110, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b0);
        chk_word("kept in sleep", pat(6'h7), data_out);
        // enable raised a cycle early, controller write, then read back
        cyc(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h9, 36'h0, 1'b1);
        cyc(bus(CS, ON, 1'b1, 1'b1, GW), 6'h9, pat(6'h9), 1'b1);
        cyc(bus(CS, ON, 1'b1, 1'b1, RD), 6'h9, 36'h0, 1'b0);
        cyc(bus(NS, OFF, 1'b1, 1'b1, RD), 6'h0, 36'h0, 1'b1);
        chk_word("controller write read back", pat(6'h9), data_out);
        chk_bit("read back pin enable", 1'b0, data_oe_n);
        give_verdict();
    end
endmodule : sync_burst_sram_interface_tb
`default_nettype wire
